// ===== common/crmkl_pkg.sv
// package: constants, types and helpers of the key lock and register masking block
//
// Function
// - mask data, key, output banks, checksum only
// - 16-bit bus: swap, double, xor mask
// - mask controls: enable, seed step, software mode
// - software mode: mask changes on seed write
// - seed read steps seed when step set
// - every bank access steps the seed
// - mask enable low forces zero mask
// - seed read: zero, generator mask, or seed
// - mask uses seed from before access
// - enabled idle kernels run dummy operations
// - 32 key lock bits, one per word
// - lock clears on reset and flushes
// - lock bits can only be set
// - locked read gives random data, sets flag
// - key words 16 to 31 always write-only
// - locked key words 0 to 7 refused for GCM
// - seed width follows bus width
// - hardware seed step only outside software mode
// - checksum access steps seed even if absent
// - one engine clock, register enable, access pulse
// - reset values of counter, seed, busy, error
`default_nettype none
package crmkl_pkg;
  // ************************************************************
  // configuration
  // ************************************************************
  localparam logic        BUS16                  = 1'b0;
  localparam int          SEED_W                 = BUS16 ? 16 : 32;
  localparam logic        SCA_PROT               = 1'b1;
  localparam logic        NO_KEY_CHECKSUM_CONFIG = 1'b0;
  localparam logic [31:0] NOSCA_CONST            = 32'h5A5A_5A5A;
  localparam logic [31:0] SEED_POLY              = BUS16 ? 32'h0000_B400 : 32'h8020_0003;
  localparam logic [31:0] PRNG_POLY              = 32'h8000_0057;
  localparam logic [31:0] PRNG_RST               = 32'h0000_0001;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [11:0] OFS_DATIN     = 12'h200;
  localparam logic [11:0] OFS_DATIN_END = 12'h210;
  localparam logic [11:0] OFS_KEY       = 12'h240;
  localparam logic [11:0] OFS_DATOUT    = 12'h2C0;
  localparam logic [11:0] OFS_KEY_CHECKSUM    = 12'h2D0;
  localparam logic [11:0] OFS_COUNT     = 12'h2D4;
  localparam logic [11:0] OFS_SEED      = 12'h2D8;
  localparam logic [11:0] OFS_KEYCTRL   = 12'h2DC;
  localparam logic [11:0] OFS_CTRL      = 12'h2E0;
  localparam logic [11:0] OFS_STATUS    = 12'h2E4;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MC_EN        = 0;
  localparam int MC_STEP      = 1;
  localparam int MC_SW        = 2;
  localparam int CTRL_START   = 0;
  localparam int CTRL_FLUSH   = 1;
  localparam int CTRL_KFLUSH  = 2;
  localparam int CTRL_CFG_LSB = 3;
  localparam logic [1:0] INSEL_XOR_OUT = 2'h1;
  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [31:0] KEY_LOCK_RST = 32'h0000_0000;
  localparam logic [31:0] KEY_PERMA_WO = 32'hFFFF_0000;
  localparam logic [31:0] GCM_KEY_MASK = 32'h0000_00FF;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [2:0]  ERR_OK       = 3'b101;
  localparam logic [2:0]  ERR_ALERT    = 3'b010;
  localparam logic        SHA_BUSY_RST = 1'b0;
  localparam logic [3:0]  FLUSH_LAST   = 4'h7;
  localparam logic [15:0] OP_LAST      = 16'h000F;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FLUSH = 2'b01,
    ST_RUN   = 2'b10
  } crmkl_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } crmkl_apb_req_s;

  typedef struct packed {
    logic       ksel;
    logic       noise;
    logic       kb_en;
    logic       ka_en;
    logic       gcm;
    logic [1:0] insel;
    logic       xorwr;
  } crmkl_cfg_s;

  localparam crmkl_cfg_s CFG_RST = '0;
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic crmkl_in_range(input logic [11:0] a, input logic [11:0] lo,
                                          input logic [11:0] hi);
    crmkl_in_range = (a >= lo) && (a < hi);
  endfunction

  function automatic logic [31:0] crmkl_spread(input logic [31:0] m);
    crmkl_spread = BUS16 ? {2{m[7:0], m[15:8]}} : m;
  endfunction
endpackage
`default_nettype wire

// ===== hdl/crmkl_maskgen.sv
// seeded mask generator with seed register
`timescale 1ns/10ps
`default_nettype none
module crmkl_maskgen
  import crmkl_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              load_i,
  input  wire logic [SEED_W-1:0] load_data_i,
  input  wire logic              step_i,
  input  wire logic              sw_mode_i,
  input  wire logic              mask_en_i,
  output logic      [SEED_W-1:0] seed_o,
  output logic      [SEED_W-1:0] gen_o,
  output logic      [SEED_W-1:0] mask_o
);
  logic [SEED_W-1:0] seed;
  logic [SEED_W-1:0] next_seed;
  logic [SEED_W-1:0] stepped;
  logic [SEED_W-1:0] poly;

  localparam logic [SEED_W-1:0] SEED_RST_W = '0;

  function automatic logic [SEED_W-1:0] mix(input logic [SEED_W-1:0] s,
                                            input logic [SEED_W-1:0] p);
    logic [SEED_W-1:0] t;
    t   = s ^ {s[SEED_W-8:0], s[SEED_W-1:SEED_W-7]};
    mix = t ^ {t[4:0], t[SEED_W-1:5]} ^ p;
  endfunction

  // ************************************************************
  // seed stepping
  // ************************************************************
  assign poly    = SEED_POLY[SEED_W-1:0];
  assign stepped = {1'b0, seed[SEED_W-1:1]} ^ (seed[0] ? poly : '0)
                 ^ {{(SEED_W-1){1'b0}}, (seed == '0)};
  assign next_seed = load_i ? load_data_i
                   : (step_i & ~sw_mode_i) ? stepped
                   : seed;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      seed <= SEED_RST_W;
    else
      seed <= next_seed;
  end

  // ************************************************************
  // mask output
  // ************************************************************
  assign gen_o  = sw_mode_i ? seed : mix(seed, poly);
  assign mask_o = mask_en_i ? gen_o : '0;
  assign seed_o = seed;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_sw_seed_hold: assert property (sw_mode_i && !load_i |=> $stable(seed))
    else $error("seed moved in software mask mode");
  a_sw_mask_direct: assert property (mask_en_i && sw_mode_i |-> mask_o == seed)
    else $error("software mode mask differs from seed");
endmodule
`default_nettype wire

// ===== hdl/crmkl_top.sv
// key lock and register masking front end with apb register slave
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module crmkl_top
  import crmkl_pkg::*;
(
  input  wire logic           CLOCK_I,
  input  wire logic           RST_N_I,
  input  wire logic           SFR_CKEN_I,
  input  wire crmkl_apb_req_s APB_I,
  output logic       [31:0]   PRDATA_O,
  output logic                PREADY_O,
  output logic                PSLVERR_O,
  output logic                ENGINE_PULSE_O,
  input  wire logic  [2:0]    MASK_CTRL_I,
  input  wire logic  [127:0]  KERNEL_RES_I,
  output logic       [127:0]  KERNEL_IN_O,
  output logic                KERNEL_A_RUN_O,
  output logic                KERNEL_B_RUN_O,
  output logic                KERNEL_A_DUMMY_O,
  output logic                KERNEL_B_DUMMY_O,
  output logic                BUSY_O,
  output logic       [2:0]    ERROR_O
);
  // ************************************************************
  // declarations
  // ************************************************************
  logic [31:0]       datin  [4];
  logic [31:0]       key    [32];
  logic [31:0]       datout [4];
  logic [31:0]       key_checksum;
  logic [127:0]      datin_blk;
  logic [127:0]      datout_blk;
  logic [11:0]       addr;
  logic [11:0]       key_off;
  logic [4:0]        key_idx;
  logic [1:0]        word_idx;
  logic              ack;
  logic              setup_ph;
  logic              acc;
  logic              wr;
  logic              rd;
  logic              hit_datin;
  logic              hit_key;
  logic              hit_datout;
  logic              hit_chk;
  logic              hit_cnt;
  logic              hit_seed;
  logic              hit_kctl;
  logic              hit_ctrl;
  logic              hit_stat;
  logic              hit_bank;
  logic              mapped;
  logic              mask_en;
  logic              mask_step;
  logic              mask_sw;
  logic              seed_load;
  logic              seed_step;
  logic [SEED_W-1:0] seed;
  logic [SEED_W-1:0] gen;
  logic [SEED_W-1:0] mask;
  logic [31:0]       m32;
  logic [31:0]       seed_rd;
  logic [31:0]       wr_plain;
  logic [31:0]       rd_mux;
  logic [31:0]       key_rd;
  logic [31:0]       chk_rd;
  logic [31:0]       status_word;
  logic [31:0]       prng;
  logic [31:0]       key_lock;
  logic [31:0]       key_write_only_bits;
  logic              locked_rd;
  logic              key_read_err;
  logic [2:0]        error;
  crmkl_cfg_s        cfg;
  crmkl_cfg_s        next_cfg;
  crmkl_state_e      state;
  crmkl_state_e      next_state;
  logic [3:0]        flush_cnt;
  logic [15:0]       calc_cnt;
  logic              run_sel;
  logic              start_req;
  logic              start_ok;
  logic              flush_full;
  logic              flush_key;
  logic              gcm_bad;
  logic              run_end;
  logic              run_a;
  logic              run_b;

  // ************************************************************
  // apb handshake and decode
  // ************************************************************
  assign addr           = APB_I.paddr;
  assign setup_ph       = APB_I.psel & APB_I.penable & ~ack & SFR_CKEN_I;
  assign acc            = APB_I.psel & APB_I.penable & ack;
  assign wr             = acc & APB_I.pwrite & mapped;
  assign rd             = acc & ~APB_I.pwrite & mapped;
  assign PREADY_O       = ack;
  assign ENGINE_PULSE_O = APB_I.psel & SFR_CKEN_I;

  assign key_off    = addr - OFS_KEY;
  assign key_idx    = key_off[6:2];
  assign word_idx   = addr[3:2];
  assign hit_datin  = crmkl_in_range(addr, OFS_DATIN, OFS_DATIN_END);
  assign hit_key    = crmkl_in_range(addr, OFS_KEY, OFS_DATOUT);
  assign hit_datout = crmkl_in_range(addr, OFS_DATOUT, OFS_KEY_CHECKSUM);
  assign hit_chk    = (addr == OFS_KEY_CHECKSUM);
  assign hit_cnt    = (addr == OFS_COUNT);
  assign hit_seed   = (addr == OFS_SEED);
  assign hit_kctl   = (addr == OFS_KEYCTRL);
  assign hit_ctrl   = (addr == OFS_CTRL);
  assign hit_stat   = (addr == OFS_STATUS);
  assign hit_bank   = hit_datin | hit_key | hit_datout | hit_chk;
  assign mapped     = (hit_bank | hit_cnt | hit_seed | hit_kctl | hit_ctrl | hit_stat)
                    & (addr[1:0] == 2'b00);

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      ack       <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      ack       <= setup_ph;
      PSLVERR_O <= setup_ph & ~mapped;
    end
  end

  // ************************************************************
  // mask generator
  // ************************************************************
  assign mask_en   = MASK_CTRL_I[MC_EN];
  assign mask_step = MASK_CTRL_I[MC_STEP];
  assign mask_sw   = MASK_CTRL_I[MC_SW];
  assign seed_load = wr & hit_seed;
  assign seed_step = (acc & mapped & hit_bank)
                   | (rd & hit_seed & mask_step);

  crmkl_maskgen u_maskgen (
    .clock_i     (CLOCK_I),
    .rst_n_i     (RST_N_I),
    .load_i      (seed_load),
    .load_data_i (APB_I.pwdata[SEED_W-1:0]),
    .step_i      (seed_step),
    .sw_mode_i   (mask_sw),
    .mask_en_i   (mask_en),
    .seed_o      (seed),
    .gen_o       (gen),
    .mask_o      (mask)
  );

  assign m32      = crmkl_spread(32'(mask));
  assign wr_plain = APB_I.pwdata ^ m32;
  assign seed_rd  = mask_sw ? 32'h0000_0000 : mask_en ? 32'(seed) : 32'(gen);

  // ************************************************************
  // read selection
  // ************************************************************
  assign key_write_only_bits    = key_lock | KEY_PERMA_WO;
  assign locked_rd = hit_key & key_write_only_bits[key_idx];
  assign key_rd    = locked_rd ? (SCA_PROT ? prng : NOSCA_CONST)
                   : key[key_idx] ^ m32;
  assign chk_rd    = NO_KEY_CHECKSUM_CONFIG ? m32 : key_checksum ^ m32;
  assign status_word = {26'h000_0000, key_read_err, error, SHA_BUSY_RST, BUSY_O};
  assign rd_mux    = hit_datin  ? datin[word_idx] ^ m32
                   : hit_key    ? key_rd
                   : hit_datout ? datout[word_idx] ^ m32
                   : hit_chk    ? chk_rd
                   : hit_cnt    ? {16'h0000, calc_cnt}
                   : hit_seed   ? seed_rd
                   : hit_kctl   ? key_lock
                   : hit_ctrl   ? {21'h00_0000, cfg, 3'b000}
                   : hit_stat   ? status_word
                   : 32'h0000_0000;

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      PRDATA_O <= 32'h0000_0000;
    else if (setup_ph & ~APB_I.pwrite)
      PRDATA_O <= mapped ? rd_mux : 32'h0000_0000;
  end

  // ************************************************************
  // random source for locked reads
  // ************************************************************
  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      prng <= PRNG_RST;
    else
      prng <= {1'b0, prng[31:1]} ^ (prng[0] ? PRNG_POLY : 32'h0000_0000);
  end

  // ************************************************************
  // register banks, not reset
  // ************************************************************
  assign datin_blk  = {datin[3], datin[2], datin[1], datin[0]};
  assign datout_blk = {datout[3], datout[2], datout[1], datout[0]};

  always_ff @(posedge CLOCK_I)
  begin
    if (wr & hit_datin)
      datin[word_idx] <= cfg.xorwr ? (datin[word_idx] ^ wr_plain) : wr_plain;
    if (wr & hit_key)
      key[key_idx] <= wr_plain;
    if (run_end)
    begin
      for (int i = 0; i < 4; i++)
        datout[i] <= KERNEL_RES_I[32*i +: 32];
    end
    else if (wr & hit_datout)
      datout[word_idx] <= wr_plain;
    if (wr & hit_chk)
      key_checksum <= wr_plain;
  end

  // ************************************************************
  // control, key lock and status flags
  // ************************************************************
  assign start_req  = wr & hit_ctrl & APB_I.pwdata[CTRL_START];
  assign flush_full = wr & hit_ctrl & APB_I.pwdata[CTRL_FLUSH];
  assign flush_key  = wr & hit_ctrl & APB_I.pwdata[CTRL_KFLUSH];
  assign next_cfg   = (wr & hit_ctrl) ? crmkl_cfg_s'(APB_I.pwdata[CTRL_CFG_LSB +: 8]) : cfg;
  assign gcm_bad    = start_req & next_cfg.gcm & (|(key_write_only_bits & GCM_KEY_MASK));
  assign start_ok   = start_req & ~flush_full & ~flush_key & ~gcm_bad
                    & (state == ST_IDLE);

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      cfg <= CFG_RST;
    else
      cfg <= next_cfg;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      key_lock <= KEY_LOCK_RST;
    else if (flush_full | flush_key)
      key_lock <= KEY_LOCK_RST;
    else if (wr & hit_kctl)
      key_lock <= key_lock | APB_I.pwdata;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      key_read_err <= 1'b0;
    else if (rd & locked_rd)
      key_read_err <= 1'b1;
    else if (flush_full)
      key_read_err <= 1'b0;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      error <= ERR_OK;
    else if (gcm_bad)
      error <= ERR_ALERT;
    else if (flush_full)
      error <= ERR_OK;
  end

  assign ERROR_O = error;

  // ************************************************************
  // engine sequencing
  // ************************************************************
  assign run_end = (state == ST_RUN) & (calc_cnt == OP_LAST);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_FLUSH: if (flush_cnt == 4'h0) next_state = ST_IDLE;
      ST_IDLE:  if (start_ok) next_state = ST_RUN;
      ST_RUN:   if (run_end) next_state = ST_IDLE;
      default:  next_state = ST_FLUSH;
    endcase
    if (flush_full)
      next_state = ST_FLUSH;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      state <= ST_FLUSH;
    else
      state <= next_state;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      flush_cnt <= FLUSH_LAST;
    else if (flush_full)
      flush_cnt <= FLUSH_LAST;
    else if ((state == ST_FLUSH) && (flush_cnt != 4'h0))
      flush_cnt <= flush_cnt - 4'h1;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
      calc_cnt <= COUNT_RST;
    else if (start_ok)
      calc_cnt <= COUNT_RST;
    else if (state == ST_RUN)
      calc_cnt <= calc_cnt + 16'h0001;
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (!RST_N_I)
    begin
      run_sel     <= 1'b0;
      KERNEL_IN_O <= '0;
    end
    else if (start_ok)
    begin
      run_sel     <= next_cfg.ksel;
      KERNEL_IN_O <= (next_cfg.insel == INSEL_XOR_OUT) ? (datin_blk ^ datout_blk)
                   : datin_blk;
    end
  end

  // ************************************************************
  // kernel activity
  // ************************************************************
  assign BUSY_O           = (state != ST_IDLE);
  assign run_a            = (state == ST_RUN) & ~run_sel;
  assign run_b            = (state == ST_RUN) & run_sel;
  assign KERNEL_A_RUN_O   = run_a;
  assign KERNEL_B_RUN_O   = run_b;
  assign KERNEL_A_DUMMY_O = cfg.noise & cfg.ka_en & ~run_a;
  assign KERNEL_B_DUMMY_O = cfg.noise & cfg.kb_en & ~run_b;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_read_setup;
    setup_ph && !APB_I.pwrite;
  endsequence

  sequence s_seed_read_sw;
    s_read_setup ##0 hit_seed ##0 mask_sw;
  endsequence

  a_ready_single: assert property (PREADY_O |=> !PREADY_O)
    else $error("pready held for more than one cycle");
  a_bank_step: assert property (acc && mapped && hit_bank && !mask_sw && !seed_load
                                |=> seed != $past(seed))
    else $error("bank access did not step the seed");
  a_mask_off: assert property (!mask_en |-> m32 == 32'h0000_0000)
    else $error("mask not zero while disabled");
  a_seed_presample: assert property (s_read_setup |=> $stable(seed))
    else $error("seed moved before the read data was taken");
  a_seed_read_sw: assert property (s_seed_read_sw |=> PRDATA_O == 32'h0000_0000)
    else $error("seed read in software mode not zero");
  a_count_plain: assert property (s_read_setup ##0 hit_cnt
                                  |=> PRDATA_O == {16'h0000, $past(calc_cnt)})
    else $error("count read was masked");
  a_lock_sticky: assert property (!(flush_full || flush_key)
                                  |=> (key_lock & $past(key_lock)) == $past(key_lock))
    else $error("key lock bit cleared by a write");
  a_lock_flush: assert property (flush_full || flush_key |=> key_lock == 32'h0000_0000)
    else $error("key lock not cleared by flush");
  a_locked_err: assert property (rd && locked_rd |=> key_read_err)
    else $error("locked key read did not raise the flag");
  a_perma_wo: assert property (hit_key && key_idx[4] |-> locked_rd)
    else $error("upper key words readable");
  a_gcm_refuse: assert property (gcm_bad && state == ST_IDLE
                                 |=> state != ST_RUN && ERROR_O == ERR_ALERT)
    else $error("gcm start with locked key was taken");
  a_dummy_real: assert property (run_a |-> !KERNEL_A_DUMMY_O)
    else $error("kernel runs dummy and real work together");
  a_reset_vals: assert property ($rose(RST_N_I)
                                 |-> BUSY_O && ERROR_O == ERR_OK && calc_cnt == COUNT_RST)
    else $error("wrong values after reset");
endmodule
`default_nettype wire

// ===== test/crmkl_kernel_model.sv
// kernel stand-in: result is the inverted kernel input
`timescale 1ns/10ps
`default_nettype none
module crmkl_kernel_model (
  input  wire logic [127:0] in_i,
  output logic      [127:0] res_o
);
  assign res_o = ~in_i;
endmodule
`default_nettype wire

// ===== test/crmkl_top_bench.sv
// self-checking bench of the masking and key lock front end
`timescale 1ns/10ps
`default_nettype none
module crmkl_top_bench
  import crmkl_pkg::*;
;
  typedef struct packed {
    logic [11:0] a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
    logic        ck;
    logic        err;
  } crmkl_row_s;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic [2:0]     mctl = 3'b001;
  logic           cken = 1'b1;
  logic           pulse;
  crmkl_apb_req_s req = '0;
  logic [31:0]    prdata;
  logic [31:0]    r;
  logic [31:0]    r2;
  logic           pready;
  logic           pslverr;
  logic           e;
  logic           busy;
  logic           arun;
  logic           brun;
  logic           adum;
  logic           bdum;
  logic [2:0]     err;
  logic [127:0]   kin;
  logic [127:0]   kres;
  int             n_mismatch = 0;
  int             cmp_count = 0;
  crmkl_row_s     rows [13] = '{
    '{OFS_SEED, 1'b1, 32'h0F0F_0F0F, 32'h0, 1'b0, 1'b0},
    '{OFS_SEED, 1'b0, 32'h0, 32'h0, 1'b1, 1'b0},
    '{OFS_DATIN, 1'b1, 32'h1234_5678, 32'h0, 1'b0, 1'b0},
    '{OFS_DATIN, 1'b0, 32'h0, 32'h1234_5678, 1'b1, 1'b0},
    '{OFS_COUNT, 1'b0, 32'h0, 32'h0, 1'b1, 1'b0},
    '{OFS_KEYCTRL, 1'b1, 32'h1, 32'h0, 1'b0, 1'b0},
    '{OFS_KEYCTRL, 1'b1, 32'h0, 32'h0, 1'b0, 1'b0},
    '{OFS_KEYCTRL, 1'b0, 32'h0, 32'h1, 1'b1, 1'b0},
    '{OFS_KEY, 1'b0, 32'h0, 32'h0, 1'b0, 1'b0},
    '{OFS_STATUS, 1'b0, 32'h0, 32'h34, 1'b1, 1'b0},
    '{OFS_CTRL, 1'b1, 32'h4, 32'h0, 1'b0, 1'b0},
    '{OFS_KEYCTRL, 1'b0, 32'h0, 32'h0, 1'b1, 1'b0},
    '{12'h000, 1'b0, 32'h0, 32'h0, 1'b1, 1'b1}};

  always #2.5 clk = ~clk;

  crmkl_top crmkl_top_inst (.CLOCK_I(clk), .RST_N_I(rst_n), .SFR_CKEN_I(cken), .APB_I(req),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .ENGINE_PULSE_O(pulse),
    .MASK_CTRL_I(mctl), .KERNEL_RES_I(kres), .KERNEL_IN_O(kin), .KERNEL_A_RUN_O(arun),
    .KERNEL_B_RUN_O(brun), .KERNEL_A_DUMMY_O(adum), .KERNEL_B_DUMMY_O(bdum),
    .BUSY_O(busy), .ERROR_O(err));
  crmkl_kernel_model crmkl_kernel_model_inst (.in_i(kin), .res_o(kres));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic stop_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic limit(input int n);
    if (n >= 100)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 100);
    r = prdata;
    e = pslverr;
    chk("engine pulse", {31'h0, pulse}, 32'h1);
    req <= '0;
    limit(n);
  endtask

  task automatic wbusy;
    int n;
    n = 0;
    @(posedge clk);
    while (busy !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    limit(n);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("reset status", r, 32'h15);
    apb(OFS_SEED, 1'b0, 32'h0);
    chk("reset seed", r, 32'h0);
    apb(OFS_COUNT, 1'b0, 32'h0);
    chk("reset count", r, 32'h0);
    wbusy();
    cken <= 1'b0;
    fork
      apb(OFS_COUNT, 1'b0, 32'h0);
      begin
        repeat (6) @(posedge clk);
        chk("wait state", {30'h0, pready, pulse}, 32'h0);
        cken <= 1'b1;
      end
    join
    chk("late count", r, 32'h0);
    apb(OFS_DATIN, 1'b0, 32'h0);
    apb(OFS_SEED, 1'b0, 32'h0);
    chk("seed stepped", {31'h0, r != 32'h0}, 32'h1);
    mctl <= 3'b101;
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (rows[i].ck) chk("row data", r, rows[i].e);
      chk("row error", {31'h0, e}, {31'h0, rows[i].err});
    end
    mctl <= 3'b100;
    apb(OFS_DATIN, 1'b0, 32'h0);
    chk("mask off", r, 32'h1D3B_5977);
    mctl <= 3'b001;
    apb(OFS_SEED, 1'b0, 32'h0);
    chk("seed kept", r, 32'h0F0F_0F0F);
    mctl <= 3'b011;
    apb(OFS_SEED, 1'b0, 32'h0);
    r2 = r;
    apb(OFS_SEED, 1'b0, 32'h0);
    chk("seed read step", {31'h0, r != r2}, 32'h1);
    apb(OFS_SEED, 1'b1, 32'h0);
    apb(OFS_KEY_CHECKSUM, 1'b0, 32'h0);
    apb(OFS_SEED, 1'b0, 32'h0);
    chk("checksum step", r, 32'h1);
    apb(OFS_SEED, 1'b1, 32'h0000_00A5);
    apb(OFS_DATIN, 1'b0, 32'h0);
    r2 = r;
    apb(OFS_SEED, 1'b1, 32'h0000_00A5);
    apb(OFS_DATIN, 1'b0, 32'h0);
    chk("mask replay", r, r2);
    apb(OFS_CTRL, 1'b1, 32'h2);
    wbusy();
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("flag flushed", r, 32'h14);
    apb(OFS_KEY + 12'h040, 1'b0, 32'h0);
    apb(OFS_STATUS, 1'b0, 32'h0);
    chk("word16 locked", r, 32'h34);
    mctl <= 3'b000;
    apb(OFS_DATIN, 1'b1, 32'h1030_5070);
    apb(OFS_CTRL, 1'b1, 32'h0000_0008);
    apb(OFS_DATIN, 1'b1, 32'h0204_0608);
    apb(OFS_CTRL, 1'b1, 32'h380);
    #1;
    chk("dummy", {30'h0, adum, bdum}, 32'h3);
    apb(OFS_CTRL, 1'b1, 32'h381);
    #1;
    chk("run", {28'h0, arun, brun, adum, bdum}, 32'h9);
    wbusy();
    apb(OFS_DATOUT, 1'b0, 32'h0);
    chk("result", r, 32'hEDCB_A987);
    apb(OFS_CTRL, 1'b1, 32'h391);
    wbusy();
    apb(OFS_DATOUT, 1'b0, 32'h0);
    chk("chained", r, 32'h0);
    apb(OFS_KEYCTRL, 1'b1, 32'h0000_0001);
    apb(OFS_CTRL, 1'b1, 32'h0000_0041);
    #1;
    chk("gcm refused", {28'h0, busy, err}, {28'h0, 1'b0, ERR_ALERT});
    apb(OFS_CTRL, 1'b1, 32'h0000_0002);
    apb(OFS_KEYCTRL, 1'b0, 32'h0);
    chk("lock flushed", r, 32'h0);
    chk("error cleared", {29'h0, err}, {29'h0, ERR_OK});
    apb(OFS_KEYCTRL, 1'b1, 32'h0000_0003);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(OFS_KEYCTRL, 1'b0, 32'h0);
    chk("lock after reset", r, 32'h0);
    chk("state after reset", {28'h0, busy, err}, {28'h0, 1'b1, ERR_OK});
    stop_test();
  end
endmodule
`default_nettype wire
